// >>> bench/risq_host.sv
// Purpose: Host model on the register port
// Assumes: Drives on falling edge
// Notes: Released bus shows inverted values
`timescale 1ns/1ps
module risq_host
(
  input wire logic clk, // Clock
  input wire logic [15:0] rdata, // Read data
  output logic io_mode, // Mode
  output logic [15:0] addr, // Offset
  output logic rd, // Read strobe
  output logic wr, // Write strobe
  output logic [15:0] wdata // Write data
);
  initial
  begin
    {io_mode, rd, wr, addr, wdata} = 35'h0;
  end
  // Read; data valid the cycle after the strobe
  task automatic rd_reg(input logic m, input logic [15:0] a,
    output logic [15:0] d);
    @(negedge clk);
    {io_mode, addr, rd} = {m, a, 1'b1};
    @(negedge clk);
    d = rdata;
    {addr, rd} = {~a, 1'b0};
  endtask
  // Write; never streaming without a DMA bit
  task automatic wr_reg(input logic [15:0] a, input logic [15:0] v);
    @(negedge clk);
    {io_mode, addr, wr} = {1'b0, a, 1'b1};
    wdata = (a == 16'h0102 && !v[10:9]) ? v & 16'hFF7F : v;
    @(negedge clk);
    {addr, wdata, wr} = {~a, ~wdata, 1'b0};
  endtask
endmodule

// >>> bench/risq_monitor.sv
// Purpose: Port checks for the status queue
// Assumes: Bound into risq_top
// Notes: Config decoded in memory mode only
`timescale 1ns/1ps
module risq_monitor #(parameter int N = 5)
(
  input wire logic clk, // Clock
  input wire logic reset, // Reset
  input wire logic io_mode, // Mode
  input wire logic [15:0] addr, // Offset
  input wire logic rd, // Read
  input wire logic [15:0] rdata, // Data
  input wire logic irq, // Interrupt
  input wire logic tx_event, // Tx pulse
  input wire logic frame_done, // Frame end
  input wire logic frame_tiny, // Tiny
  input wire logic frame_drop, // Discard
  input wire risq_pkg::risq_path_t frame_path // Path
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (reset);
  // Queue read in either decode
  sequence s_qrd;
    rd && addr == (io_mode ? 16'h0008 : 16'h0120);
  endsequence
  property p_idle; !rd |=> rdata == 16'h0000; endproperty
  a_idle: assert property (p_idle) else $error("rdata idle");
  property p_irq; tx_event |=> irq; endproperty
  a_irq: assert property (p_irq) else $error("irq late");
  property p_num; s_qrd ##0 irq |=> rdata[5:0] inside
    {6'h04, 6'h08, 6'h0C, 6'h10, 6'h12}; endproperty
  a_num: assert property (p_num) else $error("bad number");
  property p_empty; s_qrd ##0 !irq |=> rdata == 16'h0000; endproperty
  a_empty: assert property (p_empty) else $error("empty word");
  property p_cfg; rd && !io_mode && addr == 16'h0102
    |=> rdata[5:0] == 6'h03; endproperty
  a_cfg: assert property (p_cfg) else $error("cfg id");
  property p_tiny; frame_done && frame_tiny |=> frame_drop; endproperty
  a_tiny: assert property (p_tiny) else $error("tiny kept");
  property p_drop; frame_drop |-> $past(frame_done); endproperty
  a_drop: assert property (p_drop) else $error("stray drop");
  property p_path; !$stable(frame_path) |-> $past(frame_done); endproperty
  a_path: assert property (p_path) else $error("stray path");
endmodule
bind risq_top risq_monitor #(.N(N)) u_mon (.clk, .reset, .io_mode, .addr,
  .rd, .rdata, .irq, .tx_event, .frame_done, .frame_tiny, .frame_drop,
  .frame_path);

// >>> bench/tb.sv
// Purpose: Self-checking bench for risq_top
// Assumes: Inputs change on falling edge
// Notes: Host model owns the register port
`timescale 1ns/1ps
module tb;
  logic clk, reset, io_mode, rd, wr, irq, frame_drop, skip_pending;
  logic frame_done, frame_fcs_bad, frame_short, frame_tiny, frame_long;
  logic frame_back_to_back, frame_addr_pass;
  logic tx_event, buf_event, miss_ovf, col_ovf;
  logic [9:0] rx_extra_bits, tx_bits, buf_bits, miss_bits, col_bits;
  logic [15:0] addr, wdata, rdata, d;
  logic [15:0] pc [4];
  risq_pkg::risq_path_t frame_path, pe [4];
  int bad_count, n_checks;
  risq_top uut (.clk, .reset, .io_mode, .addr, .rd, .wr, .wdata, .rdata,
    .irq, .frame_done, .frame_fcs_bad, .frame_short, .frame_tiny,
    .frame_long, .rx_extra_bits, .frame_back_to_back, .frame_addr_pass,
    .tx_event, .tx_bits, .buf_event, .buf_bits, .miss_ovf, .miss_bits,
    .col_ovf, .col_bits, .frame_drop, .frame_path, .skip_pending);
  risq_host host (.clk, .rdata, .io_mode, .addr, .rd, .wr, .wdata);
  // 40 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Hang guard, far past the test length
  initial
  begin
    #100000;
    bad_count++;
    end_sim();
  end
  task automatic end_sim;
    if (bad_count == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, g);
    n_checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("FAIL %s exp %h got %h", nm, e, g);
    end
  endtask
  // Frame end and event pulses in one cycle; qualifiers flip after
  task automatic frm(input logic [3:0] q, input logic s, e3, e2, e1, e0);
    @(negedge clk);
    {frame_long, frame_tiny, frame_short, frame_fcs_bad} = q;
    {frame_back_to_back, frame_addr_pass, frame_done} = {s, s, 1'b1};
    {col_ovf, miss_ovf, buf_event, tx_event} = {e3, e2, e1, e0};
    @(negedge clk);
    {frame_long, frame_tiny, frame_short, frame_fcs_bad} = ~q;
    {frame_back_to_back, frame_addr_pass, frame_done} = {~s, ~s, 1'b0};
    {col_ovf, miss_ovf, buf_event, tx_event} = 4'h0;
  endtask
  task automatic rq(input logic m, input logic [15:0] e);
    host.rd_reg(m, m ? 16'h0008 : 16'h0120, d);
    chk("queue", e, d);
  endtask
  initial
  begin
    reset = 1'b1;
    {frame_done, tx_event, buf_event, miss_ovf, col_ovf} = 5'h0;
    {frame_long, frame_tiny, frame_short, frame_fcs_bad} = 4'h0;
    {frame_back_to_back, frame_addr_pass} = 2'h0;
    {rx_extra_bits, tx_bits, buf_bits} = {10'h215, 10'h3A1, 10'h2B2};
    {miss_bits, col_bits} = {10'h1C3, 10'h0D4};
    pc = '{16'h0000, 16'h0680, 16'h0200, 16'h0000};
    pe = '{risq_pkg::RISQ_PATH_BUFFER, risq_pkg::RISQ_PATH_STREAM,
      risq_pkg::RISQ_PATH_DMA, risq_pkg::RISQ_PATH_BUFFER};
    repeat (8) @(negedge clk);
    reset = 1'b0;
    host.rd_reg(1'b0, 16'h0102, d);
    chk("cfg", 16'h0003, d);
    rq(1'b1, 16'h0000);
    host.rd_reg(1'b0, 16'h0200, d);
    chk("unmapped", 16'h0000, d);
    // Skip spent on exactly one frame
    host.wr_reg(16'h0102, 16'h7FFF);
    host.rd_reg(1'b0, 16'h0102, d);
    chk("cfg", 16'h7F83, d);
    chk("skip", 16'h0001, {15'h0, skip_pending});
    frm(4'h0, 0, 0, 0, 0, 0);
    chk("drop", 16'h0001, {15'h0, frame_drop});
    chk("irq", 16'h0000, {15'h0, irq});
    // Five sources at once, drained in priority order
    host.wr_reg(16'h0102, 16'h0100);
    frm(4'h0, 0, 1, 1, 1, 1);
    chk("irq", 16'h0001, {15'h0, irq});
    rq(1'b0, {3'h0, rx_extra_bits[6:0], 6'h04});
    rq(1'b1, {tx_bits, 6'h08});
    rq(1'b0, {buf_bits, 6'h0C});
    rq(1'b1, {miss_bits, 6'h10});
    rq(1'b0, {col_bits, 6'h12});
    rq(1'b0, 16'h0000);
    chk("irq", 16'h0000, {15'h0, irq});
    // Each error interrupt on its own enable
    for (int i = 0; i < 3; i++)
    begin
      host.wr_reg(16'h0102, 16'h1000 << i);
      frm(i == 2 ? 4'h8 : 4'h1 << i, 0, 0, 0, 0, 0);
      rq(1'b0, {3'h1 << i, rx_extra_bits[6:0], 6'h04});
    end
    frm(4'h6, 0, 0, 0, 0, 0);
    chk("tiny", 16'h0001, {15'h0, frame_drop});
    host.wr_reg(16'h0102, 16'h0000);
    frm(4'h0, 0, 0, 0, 0, 0);
    chk("irq", 16'h0000, {15'h0, irq});
    // Delivery path per configuration
    for (int i = 0; i < 4; i++)
    begin
      host.wr_reg(16'h0102, pc[i]);
      frm(4'h0, i[0], 0, 0, 0, 0);
      chk("path", {14'h0, pe[i]}, {14'h0, frame_path});
    end
    // Second event on a shown but unread source merges its bits
    frm(4'h0, 0, 0, 0, 0, 1);
    tx_bits = 10'h04C;
    frm(4'h0, 0, 0, 0, 0, 1);
    rq(1'b0, {10'h3ED, 6'h08});
    end_sim();
  end
endmodule

// >>> core/risq_arbiter.sv
// Purpose: Choose the next source to present in the queue word
// Assumes: Lowest index wins
// Notes: Fully combinational
`timescale 1ns/1ps
module risq_arbiter #(parameter int N = 5)
(
  risq_pend_if.arb p // Pending sources
);
  // First-set priority pick, then word formation
  always_comb
  begin
    logic found;
    found = 1'b0;
    p.pick = '0;
    p.word = 16'h0000;
    for (int i = 0; i < N; i++)
    begin
      if (p.pend[i] && !found)
      begin
        found = 1'b1;
        p.pick[i] = 1'b1;
        p.word = {p.bits[i], p.num[i]};
      end
    end
    p.any = found;
  end
endmodule

// >>> core/risq_top.sv
// Purpose: Interrupt status queue and receive configuration register
// Assumes: Host bus decode given as address plus read and write strobes
// Notes: Empty queue reads as zero; a read pops the shown word
`timescale 1ns/1ps
`include "risq_cfg.svh"
// Function
// - Enabled event latches bits, presented via queue
// - Interrupt output high while anything queued
// - Exactly five sources: 4, 8, C, 10, 12
// - Queue at 120h memory, 0008h io
// - Low six bits hold source number
// - Upper ten bits hold source data
// - Config low bits always read 000011
// - Streaming used only when enabled, qualified
// - Config takes defined value at reset
// - Good frame event when its enable set
// - Receive source reports code 000100
module risq_top #(parameter int N = `RISQ_SRC_COUNT)
(
  input wire logic clk, // 40 MHz clock
  input wire logic reset, // Synchronous, active high
  input wire logic io_mode, // High: io-space decode
  input wire logic [15:0] addr, // Host byte offset
  input wire logic rd, // Read strobe, one cycle
  input wire logic wr, // Write strobe, one cycle
  input wire logic [15:0] wdata, // Write data
  output logic [15:0] rdata, // Read data, registered
  output logic irq, // Interrupt request
  input wire logic frame_done, // Received frame ends, pulse
  input wire logic frame_fcs_bad, // Frame had bad FCS
  input wire logic frame_short, // Under 64 bytes
  input wire logic frame_tiny, // Under 8 bytes
  input wire logic frame_long, // Over legal length
  input wire logic [9:0] rx_extra_bits, // Other receive status bits
  input wire logic frame_back_to_back, // Followed previous frame
  input wire logic frame_addr_pass, // Address filter passed
  input wire logic tx_event, // Transmit event pulse
  input wire logic [9:0] tx_bits, // Transmit event bits
  input wire logic buf_event, // Buffer event pulse
  input wire logic [9:0] buf_bits, // Buffer event bits
  input wire logic miss_ovf, // Missed counter overflow pulse
  input wire logic [9:0] miss_bits, // Missed counter value
  input wire logic col_ovf, // Collision counter overflow pulse
  input wire logic [9:0] col_bits, // Collision counter value
  output logic frame_drop, // Discard this frame, pulse
  output risq_pkg::risq_path_t frame_path, // Delivery path, registered
  output logic skip_pending // Skip armed for next frame
);
  localparam logic [5:0] NUMS [5] = '{`RISQ_NUM_RX, `RISQ_NUM_TX,
    `RISQ_NUM_BUF, `RISQ_NUM_MISS, `RISQ_NUM_COL};

  risq_pend_if #(.N(N)) p (); // Arbiter link

  logic [15:6] cfg_q, cfg_d; // Writable config bits
  logic skip_q, skip_d; // Armed skip
  logic [N-1:0] pend_q, pend_d; // Sticky per source
  logic [9:0] data_q [N]; // Captured source bits
  logic [9:0] data_d [N]; // Next captured bits
  logic [15:0] rdata_d; // Next read data
  logic drop_d; // Next drop pulse
  risq_pkg::risq_path_t path_d; // Next path
  logic drop_q; // Registered drop
  risq_pkg::risq_path_t path_q; // Registered path
  logic [N-1:0] ev; // Source events this cycle
  logic [9:0] ev_bits [N]; // Source data this cycle
  logic rx_hit; // Receive event enabled
  logic q_sel, c_sel; // Address decodes

  // Same queue contents in both modes; only the offset differs
  function automatic logic is_queue(input logic io, input logic [15:0] a);
    is_queue = io ? (a == `RISQ_OFF_QUEUE_IO)
                  : (a == `RISQ_OFF_QUEUE_MEM);
  endfunction

  assign q_sel = is_queue(io_mode, addr);
  assign c_sel = !io_mode && addr == `RISQ_OFF_CONFIG;

  // Receive outcome gated by config enables
  always_comb
  begin
    rx_hit = 1'b0;
    if (frame_done && !frame_tiny && !skip_q)
    begin
      if (!frame_fcs_bad && !frame_short && !frame_long)
        rx_hit = cfg_q[`RISQ_BIT_GOOD_IE];
      if (frame_fcs_bad && cfg_q[`RISQ_BIT_FCS_IE])
        rx_hit = 1'b1;
      if (frame_short && cfg_q[`RISQ_BIT_SHORT_IE])
        rx_hit = 1'b1;
      if (frame_long && cfg_q[`RISQ_BIT_LONG_IE])
        rx_hit = 1'b1;
    end
  end

  // Gather five event sources
  always_comb
  begin
    ev = '0;
    ev[risq_pkg::RISQ_SRC_RX] = rx_hit;
    ev[risq_pkg::RISQ_SRC_TX] = tx_event;
    ev[risq_pkg::RISQ_SRC_BUF] = buf_event;
    ev[risq_pkg::RISQ_SRC_MISS] = miss_ovf;
    ev[risq_pkg::RISQ_SRC_COL] = col_ovf;
    ev_bits[risq_pkg::RISQ_SRC_RX] = {frame_long, frame_short,
      frame_fcs_bad, rx_extra_bits[6:0]};
    ev_bits[risq_pkg::RISQ_SRC_TX] = tx_bits;
    ev_bits[risq_pkg::RISQ_SRC_BUF] = buf_bits;
    ev_bits[risq_pkg::RISQ_SRC_MISS] = miss_bits;
    ev_bits[risq_pkg::RISQ_SRC_COL] = col_bits;
  end

  // Feed the arbiter
  genvar g;
  generate
    for (g = 0; g < N; g++)
    begin : feed
      assign p.pend[g] = pend_q[g];
      assign p.bits[g] = data_q[g];
      assign p.num[g] = NUMS[g];
    end
  endgenerate

  risq_arbiter #(.N(N)) u_arb (
    .p(p.arb)
  );

  // Queue state: events accumulate, read pops the shown source
  always_comb
  begin
    pend_d = pend_q;
    data_d = data_q;
    if (rd && q_sel)
      pend_d = pend_q & ~p.pick;
    for (int i = 0; i < N; i++)
    begin
      if (ev[i])
      begin
        // Set wins over pop; bits merge so nothing is lost
        pend_d[i] = 1'b1;
        data_d[i] = (pend_q[i] && !(rd && q_sel && p.pick[i])) ?
          (data_q[i] | ev_bits[i]) : ev_bits[i];
      end
      else if (rd && q_sel && p.pick[i])
        data_d[i] = 10'h000;
    end
  end

  // Config, skip and delivery path
  always_comb
  begin
    cfg_d = cfg_q;
    skip_d = skip_q;
    drop_d = 1'b0;
    path_d = path_q;
    if (wr && c_sel)
    begin
      cfg_d = wdata[15:6];
      cfg_d[`RISQ_BIT_SKIP] = 1'b0; // Skip is an action bit
      if (wdata[`RISQ_BIT_SKIP])
        skip_d = 1'b1;
    end
    if (frame_done)
    begin
      drop_d = frame_tiny || skip_q;
      if (skip_q && !(wr && c_sel && wdata[`RISQ_BIT_SKIP]))
        skip_d = 1'b0;
      if (cfg_q[`RISQ_BIT_STREAM] && frame_back_to_back &&
          frame_addr_pass)
        path_d = risq_pkg::RISQ_PATH_STREAM;
      else if (cfg_q[`RISQ_BIT_DMA_ONLY])
        path_d = risq_pkg::RISQ_PATH_DMA;
      else
        path_d = risq_pkg::RISQ_PATH_BUFFER;
    end
  end

  // Read data mux
  always_comb
  begin
    rdata_d = 16'h0000;
    if (rd && q_sel)
      rdata_d = p.word;
    else if (rd && c_sel)
      rdata_d = {cfg_q, `RISQ_CONFIG_ID};
  end

  // Registers
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      cfg_q <= `RISQ_CONFIG_RESET;
      skip_q <= 1'b0;
      pend_q <= '0;
      for (int i = 0; i < N; i++)
        data_q[i] <= 10'h000;
      rdata <= 16'h0000;
      drop_q <= 1'b0;
      path_q <= risq_pkg::RISQ_PATH_BUFFER;
    end
    else
    begin
      cfg_q <= cfg_d;
      skip_q <= skip_d;
      pend_q <= pend_d;
      data_q <= data_d;
      rdata <= rdata_d;
      drop_q <= drop_d;
      path_q <= path_d;
    end
  end

  assign irq = |pend_q;
  assign frame_drop = drop_q;
  assign frame_path = path_q;
  assign skip_pending = skip_q;
endmodule

// >>> inc/risq_cfg.svh
// Purpose: Offsets, field positions, reset values for the status queue
// Assumes: 16-bit registers, byte offsets as printed
// Notes: Definitions only
`ifndef RISQ_CFG_SVH
`define RISQ_CFG_SVH
`define RISQ_OFF_CONFIG 16'h0102
`define RISQ_OFF_QUEUE_MEM 16'h0120
`define RISQ_OFF_QUEUE_IO 16'h0008
`define RISQ_NUM_RX 6'h04
`define RISQ_NUM_TX 6'h08
`define RISQ_NUM_BUF 6'h0C
`define RISQ_NUM_MISS 6'h10
`define RISQ_NUM_COL 6'h12
`define RISQ_CONFIG_ID 6'h03
`define RISQ_CONFIG_RESET 10'h000
`define RISQ_BIT_SKIP 6
`define RISQ_BIT_STREAM 7
`define RISQ_BIT_GOOD_IE 8
`define RISQ_BIT_DMA_ONLY 9
`define RISQ_BIT_AUTO_DMA 10
`define RISQ_BIT_KEEP_FCS 11
`define RISQ_BIT_FCS_IE 12
`define RISQ_BIT_SHORT_IE 13
`define RISQ_BIT_LONG_IE 14
`define RISQ_SRC_COUNT 5
`endif

// >>> inc/risq_pend_if.sv
// Purpose: Pending-word carrier between queue top and arbiter
// Assumes: One clock domain
// Notes: Arbiter picks, top pops
`timescale 1ns/1ps
interface risq_pend_if #(parameter int N = 5);
  logic [N-1:0] pend; // Sources waiting
  logic [9:0] bits [N]; // Data of each source
  logic [5:0] num [N]; // Number of each source
  logic any; // Something waiting
  logic [15:0] word; // Selected queue word
  logic [N-1:0] pick; // One-hot choice
  modport top (output pend, bits, num, input any, word, pick);
  modport arb (input pend, bits, num, output any, word, pick);
endinterface

// >>> inc/risq_pkg.sv
// Purpose: Types for the status queue
// Assumes: Constants live in risq_cfg.svh
// Notes: Source index order gives arbitration priority
package risq_pkg;
  typedef enum logic [2:0]
  {
    RISQ_SRC_RX,
    RISQ_SRC_TX,
    RISQ_SRC_BUF,
    RISQ_SRC_MISS,
    RISQ_SRC_COL
  } risq_src_t;
  typedef enum logic [1:0]
  {
    RISQ_PATH_BUFFER,
    RISQ_PATH_DMA,
    RISQ_PATH_STREAM
  } risq_path_t;
endpackage
